// ### logic/logger_net_layer.sv
// Purpose: identity command layer, identity code and memory map
// Assumes: bit-slot layer gives one bit or read slot per pulse
// Notes: a function engine above runs the function commands
//
// Overview of operation
// RL1: master sends one identity command first
// RL2: overdrive command at normal speed selects overdrive
// RL3: function commands only after identity command success
// RL4: all bytes travel least significant bit first
// RL5: 64-bit identity: family, serial, check byte
// RL6: check byte is crc of low 56
// RL7: crc x^8+x^5+x^4+1, zero start, lsb first
// RL8: master checks crc residue equals zero
// RL9: one linear byte space for all memory
// RL10: sram at 0000H to 01FFH
// RL11: register pages at 0200H to 023FH
// RL12: calibration pages at 0240H to 027FH, writable
// RL13: sample log from 1000h to 2FFFH
// RL14: pages 20 to 127 reserved, empty
// RL15: bus never writes the sample log
// RL16: writes staged through 256-bit scratchpad
// RL17: register pages locked during mission
// RL18: passwords writable, always read as zero
// RL19: calibration page last byte is crc
// RL20: page 19 mirrors page 18
// RL21: master should write whole pages
// RL22: page is address divided by 32
// RL23: normal-length reset leaves overdrive
`timescale 1ns/1ps
module logger_net_layer
	import logger_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
	parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89AB // arbitrary value
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// bit-slot layer
	input wire logic busReset,
	input wire logic resetNormalLen,
	input wire logic bitIn,
	input wire logic bitInValid,
	input wire logic readSlot,
	output logic bitOut,
	output logic overdrive,
	// function engine
	output logic funcActive,
	output logic funcCmdValid,
	output logic funcDataValid,
	output logic [7:0] funcByte,
	input wire logic txLoad,
	input wire logic [7:0] txByte,
	input wire logic alarmFlag,
	// scratchpad and copy
	input wire logic spWrEn,
	input wire logic [4:0] spWrOff,
	input wire logic [7:0] spWrData,
	input wire logic copyReq,
	input wire logic [15:0] copyAddr,
	input wire logic missionActive,
	output logic copyBusy,
	output logic copyDone,
	output logic copyRefused,
	// reads
	input wire logic rdReq,
	input wire logic [15:0] rdAddr,
	output logic rdReady,
	output logic rdValid,
	output logic [7:0] rdData,
	// internal logging control
	input wire logic logWrEn,
	input wire logic [12:0] logWrAddr,
	input wire logic [7:0] logWrData
);

	typedef enum {R_IDLE, R_CMD, R_READ, R_MATCH, R_SRCH_T, R_SRCH_C, R_SRCH_M, R_FUNC,
		R_WAIT} romState_t;

	// address decode into regions, page is addr >> 5
	function automatic region_t regionOf(input logic [15:0] a);
		if (a <= SRAM_LAST) regionOf = RG_SRAM; // [RL9] [RL10] [RL22]
		else if (a <= REG_LAST) regionOf = RG_REGS; // [RL11]
		else if (a <= CAL_LAST) regionOf = RG_CAL; // [RL12]
		else if (a <= RSV_LAST) regionOf = RG_RSV; // [RL14]
		else if (a <= LOG_LAST) regionOf = RG_LOG; // [RL13]
		else regionOf = RG_NONE;
	endfunction : regionOf

	////////////////////////////////////////////////////////////////////////
	// identity code and its check byte
	logic [2:0] initCnt_q; // bytes fed to the crc so far
	logic romReady; // check byte complete
	logic [55:0] romData; // family plus serial
	logic [7:0] romCrc; // computed check byte
	romId_t romId; // full identity code
	logic [63:0] romVec; // identity as a flat vector

	assign romData = {SERIAL_NUM, FAMILY_CODE};
	assign romReady = (initCnt_q == BIT_LAST);
	assign romId = '{crc: romCrc, serial: SERIAL_NUM, family: FAMILY_CODE}; // [RL5]
	assign romVec = romId;

	// feed seven data bytes, family first, after reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			initCnt_q <= 3'h0;
		end else if (!romReady) begin
			initCnt_q <= initCnt_q + 3'h1; // [RL6]
		end
	end

	crc8_engine romCrcGen (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(1'b0),
		.load(!romReady), // [RL6]
		.data(romData[{initCnt_q, 3'h0} +: 8]),
		.crc(romCrc)
	);

	////////////////////////////////////////////////////////////////////////
	// byte assembly and transmit shifter
	romState_t state_q, state_d; // identity layer state
	logic [5:0] romIdx_q, romIdx_d; // identity bit index
	logic overdrive_q, overdrive_d; // fast timing selected
	logic resumeOk_q, resumeOk_d; // last selection was this device
	logic bitOut_q, bitOut_d; // bit for the current read slot
	logic [7:0] rxShift_q; // incoming byte
	logic [2:0] rxCnt_q; // bits received in this byte
	logic [7:0] txShift_q; // outgoing function byte
	logic funcFirst_q; // next function byte is the command
	logic funcCmdValid_q, funcDataValid_q; // byte pulses
	logic [7:0] funcByte_q; // last received function byte
	logic rxTaking; // states that gather bytes
	logic byteDone; // eighth bit of a byte arrives
	logic [7:0] rxByte; // completed byte
	logic romBit; // identity bit at the index
	logic lastIdx; // index at bit 63

	assign rxTaking = (state_q == R_CMD) || (state_q == R_FUNC);
	assign byteDone = rxTaking && bitInValid && (rxCnt_q == BIT_LAST);
	assign rxByte = {bitIn, rxShift_q[7:1]}; // [RL4]
	assign romBit = romVec[romIdx_q];
	assign lastIdx = (romIdx_q == ROM_LAST_IDX);

	// bits enter at the top, first ends in bit 0
	always_ff @(posedge mclk) begin
		if (!rst_n || busReset) begin
			rxShift_q <= 8'h00;
			rxCnt_q <= 3'h0;
		end else if (rxTaking && bitInValid) begin
			rxShift_q <= rxByte; // [RL4]
			rxCnt_q <= rxCnt_q + 3'h1;
		end
	end

	// transmit shifter, lsb first, refills with ones
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			txShift_q <= 8'hFF;
		end else if (txLoad) begin
			txShift_q <= txByte;
		end else if (readSlot && state_q == R_FUNC) begin
			txShift_q <= {1'b1, txShift_q[7:1]}; // [RL4]
		end
	end

	// function bytes upward, first after selection is the command
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			funcFirst_q <= 1'b1;
			funcCmdValid_q <= 1'b0;
			funcDataValid_q <= 1'b0;
			funcByte_q <= 8'h00;
		end else begin
			funcCmdValid_q <= byteDone && state_q == R_FUNC && funcFirst_q; // [RL3]
			funcDataValid_q <= byteDone && state_q == R_FUNC && !funcFirst_q;
			if (byteDone && state_q == R_FUNC) begin
				funcByte_q <= rxByte;
				funcFirst_q <= 1'b0;
			end
			if (busReset) begin
				funcFirst_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// identity layer sequencing
	always_comb begin
		state_d = state_q;
		romIdx_d = romIdx_q;
		overdrive_d = overdrive_q;
		resumeOk_d = resumeOk_q;
		bitOut_d = bitOut_q;
		unique case (state_q)
			R_IDLE, R_WAIT: begin // wait for a bus reset
			end
			R_CMD: begin
				romIdx_d = 6'h00;
				if (byteDone) begin
					unique case (rxByte)
						CMD_READ: state_d = R_READ;
						CMD_MATCH: state_d = R_MATCH;
						CMD_SEARCH: state_d = R_SRCH_T;
						CMD_CSEARCH: state_d = alarmFlag ? R_SRCH_T : R_WAIT;
						CMD_SKIP: begin
							state_d = R_FUNC;
							resumeOk_d = 1'b0;
						end
						CMD_OD_SKIP: begin
							state_d = R_FUNC;
							resumeOk_d = 1'b0;
							overdrive_d = 1'b1; // [RL2]
						end
						CMD_OD_MATCH: begin
							state_d = R_MATCH;
							overdrive_d = 1'b1; // [RL2]
						end
						CMD_RESUME: state_d = resumeOk_q ? R_FUNC : R_WAIT;
						default: state_d = R_WAIT; // only identity commands open the link [RL1]
					endcase
				end
			end
			R_READ: if (readSlot) begin // send the identity lsb first
				bitOut_d = romBit; // [RL4]
				romIdx_d = romIdx_q + 6'h01;
				if (lastIdx) state_d = R_FUNC; // [RL3]
			end
			R_MATCH: if (bitInValid) begin // compare each written bit
				romIdx_d = romIdx_q + 6'h01;
				if (bitIn != romBit) begin
					state_d = R_WAIT;
					resumeOk_d = 1'b0;
				end else if (lastIdx) begin
					state_d = R_FUNC; // [RL3]
					resumeOk_d = 1'b1;
				end
			end
			R_SRCH_T: if (readSlot) begin // true bit
				bitOut_d = romBit;
				state_d = R_SRCH_C;
			end
			R_SRCH_C: if (readSlot) begin // complement bit
				bitOut_d = !romBit;
				state_d = R_SRCH_M;
			end
			R_SRCH_M: if (bitInValid) begin // master direction bit
				romIdx_d = romIdx_q + 6'h01;
				if (bitIn != romBit) begin
					state_d = R_WAIT;
					resumeOk_d = 1'b0;
				end else if (lastIdx) begin
					state_d = R_FUNC; // [RL3]
					resumeOk_d = 1'b1;
				end else begin
					state_d = R_SRCH_T;
				end
			end
			R_FUNC: if (readSlot) begin // function engine owns read slots
				bitOut_d = txShift_q[0]; // [RL4]
			end
		endcase
		// bus reset restarts from any state
		if (busReset) begin
			state_d = romReady ? R_CMD : R_IDLE;
			bitOut_d = 1'b1;
			if (resetNormalLen) overdrive_d = 1'b0; // [RL23]
		end
	end

	// state registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= R_IDLE;
			romIdx_q <= 6'h00;
			overdrive_q <= 1'b0;
			resumeOk_q <= 1'b0;
			bitOut_q <= 1'b1;
		end else begin
			state_q <= state_d;
			romIdx_q <= romIdx_d;
			overdrive_q <= overdrive_d;
			resumeOk_q <= resumeOk_d;
			bitOut_q <= bitOut_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// scratchpad staging and page copy
	typedef enum {C_IDLE, C_RUN} copyState_t;
	copyState_t cState_q; // copy engine state
	logic [7:0] pad_q [PAD_BYTES]; // 32-byte scratchpad, outside the map
	logic [4:0] cCnt_q; // byte within the page
	logic cPass_q; // second pass writes the mirror page
	logic cToCal_q; // target is calibration memory
	logic [9:0] cBase_q; // page base in the main store
	logic copyDone_q, copyRefused_q; // result pulses
	region_t copyRegion; // region of the copy target
	logic copyAllowed; // target may be written
	logic copyRun; // copy owns the main store
	logic cLast; // last byte of the final pass
	logic [7:0] calCrc; // crc of bytes 0..30
	logic [7:0] cByte; // byte being written
	logic [9:0] cWrAddr; // write address this cycle

	assign copyRegion = regionOf(copyAddr);
	assign copyAllowed = (copyRegion == RG_SRAM) || (copyRegion == RG_CAL) ||
		(copyRegion == RG_REGS && !missionActive); // [RL15] [RL14] [RL17]
	assign copyRun = (cState_q == C_RUN);
	assign cLast = (cCnt_q == PAGE_LAST_BYTE) && (!cToCal_q || cPass_q);
	assign cByte = (cToCal_q && cCnt_q == PAGE_LAST_BYTE) ? calCrc : pad_q[cCnt_q]; // [RL19]
	assign cWrAddr = (cPass_q ? CAL_MIRROR : cBase_q) | {5'h00, cCnt_q}; // [RL20]

	// only a selected function engine writes the pad
	always_ff @(posedge mclk) begin
		if (spWrEn && funcActive && !copyRun) begin
			pad_q[spWrOff] <= spWrData; // [RL16]
		end
	end

	// copy walks 32 bytes, calibration twice
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cState_q <= C_IDLE;
			cCnt_q <= 5'h00;
			cPass_q <= 1'b0;
			cToCal_q <= 1'b0;
			cBase_q <= 10'h000;
			copyDone_q <= 1'b0;
			copyRefused_q <= 1'b0;
		end else begin
			copyDone_q <= copyRun && cLast;
			copyRefused_q <= !copyRun && copyReq && !copyAllowed;
			if (!copyRun && copyReq && copyAllowed) begin
				cState_q <= C_RUN; // [RL16]
				cCnt_q <= 5'h00;
				cPass_q <= 1'b0;
				cToCal_q <= (copyRegion == RG_CAL);
				cBase_q <= (copyRegion == RG_CAL) ? CAL_BASE[9:0] :
					{copyAddr[9:PAGE_SHIFT], 5'h00}; // whole page only [RL22] [RL21]
			end else if (copyRun) begin
				cCnt_q <= cCnt_q + 5'h01;
				if (cCnt_q == PAGE_LAST_BYTE) cPass_q <= 1'b1;
				if (cLast) cState_q <= C_IDLE;
			end
		end
	end

	crc8_engine calCrcGen (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(!copyRun),
		.load(copyRun && cToCal_q && !cPass_q && cCnt_q != PAGE_LAST_BYTE), // [RL19]
		.data(pad_q[cCnt_q]),
		.crc(calCrc)
	);

	////////////////////////////////////////////////////////////////////////
	// stores and read pipeline
	memPort_t mainPort, logPort; // store accesses
	logic [7:0] mainRd, logRd; // store outputs
	region_t rdRegion; // region of the read address
	logic rdTake; // read accepted this cycle
	logic [15:0] logOff; // offset into the log
	logic rdHide; // password bytes read as zero
	logic rd1Valid_q, rdValid_q; // pipeline valids
	region_t rd1Region_q; // region at stage one
	logic rd1Hide_q; // password at stage one
	logic [7:0] rdData_q; // answer byte

	assign rdRegion = regionOf(rdAddr);
	assign rdReady = !copyRun && !logWrEn;
	assign rdTake = rdReq && rdReady;
	assign logOff = rdAddr - LOG_BASE;
	assign rdHide = (rdRegion == RG_REGS) && (rdAddr >= PW_BASE); // [RL18]
	assign mainPort = copyRun ? '{en: 1'b1, we: 1'b1, addr: {3'h0, cWrAddr}, wdata: cByte} :
		'{en: rdTake, we: 1'b0, addr: rdAddr[12:0], wdata: 8'h00};
	// only the logging control writes the log [RL15]
	assign logPort = logWrEn ? '{en: 1'b1, we: 1'b1, addr: logWrAddr, wdata: logWrData} :
		'{en: rdTake && rdRegion == RG_LOG, we: 1'b0, addr: logOff[12:0], wdata: 8'h00};

	byte_store #(.DEPTH(MAIN_DEPTH), .AW(MAIN_AW)) mainStore (
		.mclk(mclk),
		.rst_n(rst_n),
		.port(mainPort),
		.rdata(mainRd)
	);

	byte_store #(.DEPTH(LOG_DEPTH), .AW(LOG_AW)) logStore (
		.mclk(mclk),
		.rst_n(rst_n),
		.port(logPort),
		.rdata(logRd)
	);

	// two-stage read: store register, then region select
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd1Valid_q <= 1'b0;
			rd1Region_q <= RG_NONE;
			rd1Hide_q <= 1'b0;
			rdValid_q <= 1'b0;
			rdData_q <= 8'h00;
		end else begin
			rd1Valid_q <= rdTake;
			rd1Region_q <= rdRegion;
			rd1Hide_q <= rdHide;
			rdValid_q <= rd1Valid_q;
			if (rd1Valid_q) begin
				unique case (rd1Region_q)
					RG_SRAM, RG_CAL: rdData_q <= mainRd;
					RG_REGS: rdData_q <= rd1Hide_q ? 8'h00 : mainRd; // [RL18]
					RG_LOG: rdData_q <= logRd; // [RL13]
					RG_RSV, RG_NONE: rdData_q <= 8'h00; // no storage [RL14]
				endcase
			end
		end
	end

	// outputs
	assign bitOut = bitOut_q;
	assign overdrive = overdrive_q;
	assign funcActive = (state_q == R_FUNC); // [RL3]
	assign funcCmdValid = funcCmdValid_q;
	assign funcDataValid = funcDataValid_q;
	assign funcByte = funcByte_q;
	assign copyBusy = copyRun;
	assign copyDone = copyDone_q;
	assign copyRefused = copyRefused_q;
	assign rdValid = rdValid_q;
	assign rdData = rdData_q;

endmodule : logger_net_layer

// ### logic/logger_pkg.sv
// Purpose: constants and types of the logger net layer
// Assumes: 16-bit byte addresses, 32-byte pages
// Notes: command codes are arbitrary
package logger_pkg;

	// identity code layout
	localparam int ROM_BITS = 64;
	localparam int ROM_DATA_BYTES = 7;
	localparam logic [5:0] ROM_LAST_IDX = 6'h3F;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// crc x^8+x^5+x^4+1, reflected for right shifts
	localparam logic [7:0] CRC_POLY = 8'h8C;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// identity command codes (arbitrary values)
	localparam logic [7:0] CMD_READ = 8'h11;
	localparam logic [7:0] CMD_MATCH = 8'h22;
	localparam logic [7:0] CMD_SEARCH = 8'h33;
	localparam logic [7:0] CMD_CSEARCH = 8'h44;
	localparam logic [7:0] CMD_SKIP = 8'h55;
	localparam logic [7:0] CMD_OD_SKIP = 8'h66;
	localparam logic [7:0] CMD_OD_MATCH = 8'h77;
	localparam logic [7:0] CMD_RESUME = 8'h88;

	// linear memory map
	localparam int PAGE_SHIFT = 5;
	localparam logic [4:0] PAGE_LAST_BYTE = 5'h1F;
	localparam logic [15:0] SRAM_LAST = 16'h01FF;
	localparam logic [15:0] REG_BASE = 16'h0200;
	localparam logic [15:0] REG_LAST = 16'h023F;
	localparam logic [15:0] PW_BASE = 16'h0228;
	localparam logic [15:0] CAL_BASE = 16'h0240;
	localparam logic [15:0] CAL_LAST = 16'h027F;
	localparam logic [15:0] RSV_LAST = 16'h0FFF;
	localparam logic [15:0] LOG_BASE = 16'h1000;
	localparam logic [15:0] LOG_LAST = 16'h2FFF;
	localparam logic [9:0] CAL_MIRROR = 10'h260;
	localparam int MAIN_DEPTH = 640;
	localparam int MAIN_AW = 10;
	localparam int LOG_DEPTH = 8192;
	localparam int LOG_AW = 13;
	localparam int PAD_BYTES = 32;

	// address regions
	typedef enum logic [2:0] {RG_SRAM, RG_REGS, RG_CAL, RG_RSV, RG_LOG, RG_NONE} region_t;

	// identity code, family in the low byte
	typedef struct packed {
		logic [7:0] crc;
		logic [47:0] serial;
		logic [7:0] family;
	} romId_t;

	// one access to a byte store
	typedef struct packed {
		logic en;
		logic we;
		logic [12:0] addr;
		logic [7:0] wdata;
	} memPort_t;

endpackage : logger_pkg

// ### logic/crc8_engine.sv
// Purpose: byte-wide crc-8 accumulator
// Assumes: lsb of each byte enters first
// Notes: clear has priority over load
`timescale 1ns/1ps
module crc8_engine
	import logger_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control
	input wire logic clear,
	input wire logic load,
	input wire logic [7:0] data,
	// result
	output logic [7:0] crc
);

	logic [7:0] crc_q; // running remainder
	logic [7:0] crc_d; // remainder after this byte

	////////////////////////////////////////////////////////////////////////
	// eight serial steps, lsb first
	always_comb begin
		crc_d = crc_q;
		for (int i = 0; i < 8; i++) begin
			if (crc_d[0] ^ data[i]) begin // feedback bit set
				crc_d = {1'b0, crc_d[7:1]} ^ CRC_POLY; // [RL7]
			end else begin
				crc_d = {1'b0, crc_d[7:1]}; // [RL7]
			end
		end
	end

	// remainder register, starts from zero
	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			crc_q <= CRC_INIT; // [RL7]
		end else if (load) begin
			crc_q <= crc_d;
		end
	end

	assign crc = crc_q;

endmodule : crc8_engine

// ### logic/byte_store.sv
// Purpose: single-port byte memory with registered read data
// Assumes: one access per cycle
// Notes: reads and writes never share a cycle
`timescale 1ns/1ps
module byte_store
	import logger_pkg::*;
#(
	parameter int DEPTH = MAIN_DEPTH,
	parameter int AW = MAIN_AW
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// access
	input memPort_t port,
	output logic [7:0] rdata
);

	logic [7:0] mem [DEPTH]; // storage, not reset
	logic [AW-1:0] idx; // word index
	logic [7:0] rdata_q; // read register

	assign idx = port.addr[AW-1:0];

	////////////////////////////////////////////////////////////////////////
	// write port
	always_ff @(posedge mclk) begin
		if (port.en && port.we) begin
			mem[idx] <= port.wdata;
		end
	end

	// read register, reset so the output is defined
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (port.en && !port.we) begin
			rdata_q <= mem[idx];
		end
	end

	assign rdata = rdata_q;

endmodule : byte_store

// ### dv/logger_net_layer_chk.sv
// Purpose: port checker for the logger net layer
// Assumes: one clock, sync active-low reset
// Notes: latencies as in the copy and read timing
`timescale 1ns/1ps
module logger_net_layer_chk
	import logger_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// link side
	input wire logic busReset,
	input wire logic resetNormalLen,
	input wire logic bitInValid,
	input wire logic bitOut,
	input wire logic overdrive,
	input wire logic funcActive,
	input wire logic funcCmdValid,
	// copy and read
	input wire logic copyReq,
	input wire logic [15:0] copyAddr,
	input wire logic missionActive,
	input wire logic copyBusy,
	input wire logic copyDone,
	input wire logic copyRefused,
	input wire logic rdReq,
	input wire logic [15:0] rdAddr,
	input wire logic rdReady,
	input wire logic rdValid,
	input wire logic [7:0] rdData
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// accepted requests, targets
	wire logic cpGo = copyReq && !copyBusy;
	wire logic rdGo = rdReq && rdReady;
	wire logic cpSram = copyAddr <= SRAM_LAST;
	wire logic cpCal = copyAddr >= CAL_BASE && copyAddr <= CAL_LAST;
	wire logic cpReg = copyAddr >= REG_BASE && copyAddr <= REG_LAST;
	wire logic cpOut = copyAddr > CAL_LAST; // reserved, log and beyond
	wire logic rdZero = (rdAddr >= PW_BASE && rdAddr <= REG_LAST) || rdAddr > CAL_LAST && rdAddr < LOG_BASE;
	// one page, or a page pair for the mirror
	sequence pageCopy; copyBusy ##[30:34] copyDone; endsequence
	sequence calCopy; copyBusy ##[62:66] copyDone; endsequence
	////////////////////////////////////////////////////////////////
	od_enter_a: assert property ($rose(overdrive) |-> $past(bitInValid))
		else $error("overdrive rose without a bit");
	od_leave_a: assert property (busReset && resetNormalLen |=> !overdrive)
		else $error("normal reset kept overdrive");
	func_gate_a: assert property (funcCmdValid |-> $past(funcActive))
		else $error("byte outside function layer");
	bus_reset_a: assert property (busReset |=> bitOut && !funcActive)
		else $error("bus reset left layer open");
	sram_copy_a: assert property (cpGo && cpSram |=> pageCopy)
		else $error("page copy timing wrong");
	cal_copy_a: assert property (cpGo && cpCal |=> calCopy)
		else $error("cal copy timing wrong");
	reg_lock_a: assert property (cpGo && cpReg && missionActive |=> copyRefused && !copyBusy)
		else $error("register copy during mission");
	log_ro_a: assert property (cpGo && cpOut |=> copyRefused && !copyBusy)
		else $error("copy into reserved or log");
	rd_hidden_a: assert property (rdGo && rdZero |-> ##2 (rdValid && rdData == 8'h00))
		else $error("hidden byte not zero");
endmodule : logger_net_layer_chk
////////////////////////////////////////////////////////////////
bind logger_net_layer logger_net_layer_chk u_chk (.*);

// ### dv/link_master.sv
// Purpose: bus master model on the bit-slot side
// Assumes: slots change just after a rising edge
// Notes: gap adds idle cycles before write slots for a slow master
`timescale 1ns/1ps
module link_master
	import logger_pkg::*;
(
	// clock
	input wire logic mclk,
	// slot side
	input wire logic bitOut,
	output logic busReset = 1'h0,
	output logic resetNormalLen = 1'h0,
	output logic bitIn = 1'h1,
	output logic bitInValid = 1'h0,
	output logic readSlot = 1'h0
);
	int gap = 0; // idle cycles before each write slot
	////////////////////////////////////////////////////////////////
	// reset pulse, length flag beside it
	task automatic busRst(input logic nl);
		@(posedge mclk);
		busReset <= 1'h1;
		resetNormalLen <= nl;
		@(posedge mclk);
		busReset <= 1'h0;
		resetNormalLen <= ~nl;
	endtask : busRst
	// one write slot, released line shows the inverse
	task automatic sendBit(input logic b);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		bitIn <= b;
		bitInValid <= 1'h1;
		@(posedge mclk);
		bitIn <= ~b;
		bitInValid <= 1'h0;
	endtask : sendBit
	// command or data byte
	task automatic sendByte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) sendBit(v[i]);
	endtask : sendByte
	// one read slot; bitOut stands until the next slot
	task automatic readBit(output logic b);
		@(posedge mclk);
		readSlot <= 1'h1;
		@(posedge mclk);
		readSlot <= 1'h0;
		@(posedge mclk);
		#1 b = bitOut;
	endtask : readBit
endmodule : link_master

// ### dv/logger_net_layer_tb.sv
// Purpose: self-checking bench for the logger net layer
// Assumes: link master model drives the bit-slot side
// Notes: stores start unknown, unwritten bytes fail
`timescale 1ns/1ps
module logger_net_layer_tb
	import logger_pkg::*;
;
	localparam logic [7:0] FAM = 8'h3E; // arbitrary value
	localparam logic [47:0] SER = 48'hC0FF_EE12_3456; // arbitrary value
	typedef struct packed {logic al; logic [7:0] cmd; logic od; logic fa; logic bo;} row_t;
	// alarm, command, then overdrive, layer open and bitOut after one slot
	row_t rows [6] = '{'{1'h0, CMD_SKIP, 1'h0, 1'h1, 1'h0},
		'{1'h0, CMD_RESUME, 1'h0, 1'h0, 1'h1}, '{1'h0, 8'h00, 1'h0, 1'h0, 1'h1},
		'{1'h0, CMD_CSEARCH, 1'h0, 1'h0, 1'h1}, '{1'h1, CMD_CSEARCH, 1'h0, 1'h0, FAM[0]},
		'{1'h0, CMD_OD_SKIP, 1'h1, 1'h1, 1'h1}};
	// copies that land, then refused ones (first under mission)
	logic [15:0] good [4] = '{16'h0020, 16'h0257, 16'h0200, 16'h0220};
	logic [15:0] bad [5] = '{16'h0200, 16'h0280, 16'h0FE0, 16'h1000, 16'h2FE0};
	logic mclk = 1'h0, rst_n = 1'h0, txLoad = 1'h0, alarmFlag = 1'h0;
	logic spWrEn = 1'h0, copyReq = 1'h0, missionActive = 1'h0, rdReq = 1'h0, logWrEn = 1'h0;
	logic [4:0] spWrOff = 5'h00;
	logic [7:0] spWrData = 8'h00, logWrData = 8'h00, txByte = 8'h00;
	logic [12:0] logWrAddr = 13'h0000;
	logic [15:0] copyAddr = 16'h0000, rdAddr = 16'h0000;
	wire logic busReset, resetNormalLen, bitIn, bitInValid, readSlot, bitOut, overdrive;
	wire logic funcActive, funcCmdValid, copyBusy, copyDone, copyRefused, rdReady, rdValid;
	wire logic funcDataValid;
	wire logic [7:0] funcByte, rdData;
	int num_errors = 0, check_count = 0, cycles = 0;
	initial forever #10 mclk = ~mclk;
	logger_net_layer #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) u_logger_net_layer (.*);
	link_master u_link_master (.*);
	////////////////////////////////////////////////////////////////
	// serial crc, lsb first, from c0
	function automatic logic [7:0] crcB(input logic [7:0] c0, input logic [63:0] v, input int n);
		logic [7:0] c;
		c = c0;
		for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ v[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : crcB
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	// request held until rdReady, data taken with rdValid
	task automatic rdChk(input logic [15:0] a, input logic [7:0] e, input string msg);
		@(posedge mclk);
		rdReq <= 1'h1;
		rdAddr <= a;
		do @(posedge mclk); while (rdReady !== 1'h1);
		rdReq <= 1'h0;
		repeat (4) begin
			@(posedge mclk);
			#1 if (rdValid === 1'h1) break;
		end
		chk(rdData, e, msg);
	endtask : rdChk
	// copy request; outcome is {done, refused}
	task automatic cpChk(input logic [15:0] a, input logic m, input logic [1:0] e);
		logic [1:0] r;
		@(posedge mclk);
		copyReq <= 1'h1;
		copyAddr <= a;
		missionActive <= m;
		@(posedge mclk);
		copyReq <= 1'h0;
		repeat (80) begin
			#1 r = {copyDone, copyRefused};
			if (r != 2'h0) break;
			@(posedge mclk);
		end
		chk(r, e, "copy outcome");
	endtask : cpChk
	// hang guard, far above the run's length of under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		romId_t id;
		logic [7:0] c;
		logic b;
		repeat (20) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (10) @(posedge mclk);
		#1 chk({bitOut, overdrive, funcActive, copyBusy}, 4'h8, "reset state");
		u_link_master.busRst(1'h1);
		u_link_master.sendByte(CMD_READ);
		for (int i = 0; i < ROM_BITS; i++) u_link_master.readBit(id[i]);
		chk(id, {crcB(CRC_INIT, {8'h00, SER, FAM}, 56), SER, FAM}, "identity");
		chk(crcB(CRC_INIT, id, ROM_BITS), 0, "crc residue");
		#1 chk(funcActive, 1, "open after read");
		@(posedge mclk);
		txLoad <= 1'h1;
		txByte <= 8'hFE;
		@(posedge mclk);
		txLoad <= 1'h0;
		foreach (rows[i]) begin
			@(posedge mclk) alarmFlag <= rows[i].al;
			u_link_master.busRst(1'h1);
			u_link_master.sendByte(rows[i].cmd);
			u_link_master.readBit(b);
			chk({overdrive, funcActive, b}, rows[i][2:0], "command row");
		end
		// overdrive match, short reset, resume with a slow master
		u_link_master.busRst(1'h1);
		u_link_master.sendByte(CMD_OD_MATCH);
		for (int i = 0; i < 8; i++) u_link_master.sendByte(id[i*8 +: 8]);
		repeat (2) @(posedge mclk);
		#1 chk({overdrive, funcActive}, 2'h3, "after od match");
		u_link_master.busRst(1'h0);
		u_link_master.gap = 3;
		u_link_master.sendByte(CMD_RESUME);
		u_link_master.sendByte(8'hA5);
		#1 chk({overdrive, funcActive, funcCmdValid, funcByte}, 11'h7A5, "resumed");
		u_link_master.sendByte(8'h3C);
		u_link_master.gap = 0;
		#1 chk({funcDataValid, funcByte}, 9'h13C, "data byte");
		u_link_master.busRst(1'h1);
		u_link_master.sendByte(CMD_SKIP);
		chk(overdrive, 0, "normal reset");
		// whole page into the scratchpad
		for (int i = 0; i < PAD_BYTES; i++) begin
			@(posedge mclk);
			spWrEn <= 1'h1;
			spWrOff <= 5'(i);
			spWrData <= 8'h40 + 8'(i);
		end
		@(posedge mclk);
		spWrEn <= 1'h0;
		foreach (good[i]) cpChk(good[i], 1'h0, 2'h2);
		foreach (bad[i]) cpChk(bad[i], i == 0, 2'h1);
		rdChk(16'h0025, 8'h45, "sram");
		rdChk(16'h0245, 8'h45, "calibration");
		rdChk(16'h0265, 8'h45, "mirror page");
		c = CRC_INIT;
		for (int i = 0; i < 31; i++) c = crcB(c, 64'(8'h40 + 8'(i)), 8);
		rdChk(16'h027F, c, "calibration crc");
		rdChk(16'h0210, 8'h50, "register page");
		rdChk(16'h0228, 8'h00, "password");
		rdChk(16'h0500, 8'h00, "reserved");
		@(posedge mclk);
		logWrEn <= 1'h1;
		logWrAddr <= 13'h0ABC;
		logWrData <= 8'h5E;
		@(posedge mclk);
		logWrEn <= 1'h0;
		rdChk(16'h1ABC, 8'h5E, "log");
		print_verdict();
	end
endmodule : logger_net_layer_tb
